// ==== design/swc_map.svh ====
// Function
// - eight low-side channels, each driven by its own stored mode state
// - after supply start-up every channel's input-side mode is OFF
// - reset pin low forces all registers to defaults and minimum current
// - all eight channels in Clear puts the device into low-power standby
// - per-channel select field picks one of four direct input pins
// - an open direct input pin reads low and switches its channels off
// - leaving power-on or external reset, all channels are in OFF mode
// - while reset is active every output stage is held in Clear
// - a clamping channel may switch on again only after clamping ends
// - output follows SPI on/off command, or its selected pin in input mode
// - in input mode pin high equals ON command, pin low equals OFF
// - serial output floats while chip select high or reset low; the enable drops one clock after chip select rises
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

`define SWC_CHANNELS        8
`define SWC_PINS            4
`define SWC_FRAME_BITS      5'h10
`define SWC_FRAME_LAST      5'h0F
`define SWC_SYS_CLK_HZ      64'h00000000017D7840
`define SWC_MS_PER_S        64'h00000000000003E8
`define SWC_US_PER_S        64'h00000000000F4240
`define SWC_STBY_WAKE_MS    64'h00000000000000C8
`define SWC_RST_WAKE_US     64'h00000000000000C8

`define SWC_MODE_OFF        2'h0
`define SWC_MODE_ON         2'h1
`define SWC_MODE_CLEAR      2'h2
`define SWC_MODE_INPUT      2'h3
`define SWC_OP_MODE         1'h0
`define SWC_OP_PINSEL       1'h1
`define SWC_PINSEL_RESET    2'h0
`define SWC_SO_MARKER       1'h1

`endif

// ==== design/swc_pkg.sv ====
package swc_pkg;

    typedef enum logic [1:0] {
        SWC_OFF,
        SWC_ON,
        SWC_CLEAR,
        SWC_INPUT
    } swc_mode_t;

    typedef struct packed {
        logic       op;
        logic [2:0] channel;
        logic [1:0] value;
        logic       broadcast;
        logic [8:0] spare;
    } swc_frame_t;

    typedef struct packed {
        logic       marker;
        logic       standby;
        logic       wake_busy;
        logic       ready;
        logic [3:0] zero;
        logic [7:0] clamp;
    } swc_status_t;

endpackage

// ==== design/swc_spi_link.sv ====
`timescale 1ns/100ps
`include "swc_map.svh"

module swc_spi_link (
    input  wire logic               rst_n_i,     // reset, low active
    input  wire logic               spi_sclk_i,  // link clock
    input  wire logic               spi_cs_n_i,  // chip select, low active
    input  wire logic               spi_si_i,    // serial data in
    input  wire swc_pkg::swc_status_t status_i,  // held steady during frames
    output swc_pkg::swc_frame_t     frame_o,     // last full 16-bit word
    output logic                    frame_tog_o, // toggles per full word
    output logic                    extra_tog_o, // toggles on a 17th bit
    output logic                    so_o         // serial data out
);
    logic [4:0]  bit_cnt;
    logic [14:0] shift;

    // chip select high clears the frame state; sclk may be stopped then
    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt != `SWC_FRAME_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge spi_sclk_i) begin
        shift <= {shift[13:0], spi_si_i};
    end

    always_ff @(posedge spi_sclk_i) begin
        if (!spi_cs_n_i && bit_cnt == `SWC_FRAME_LAST) begin
            frame_o <= {shift, spi_si_i};
        end
    end

    // toggles restart with the system reset; sclk is idle then, so release is quiet
    always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_tog_o <= 1'b0;
        end else if (!spi_cs_n_i && bit_cnt == `SWC_FRAME_LAST) begin
            frame_tog_o <= ~frame_tog_o;
        end
    end

    // an overlong frame is flagged so the whole frame is discarded
    always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            extra_tog_o <= 1'b0;
        end else if (!spi_cs_n_i && bit_cnt == `SWC_FRAME_BITS) begin
            extra_tog_o <= ~extra_tog_o;
        end
    end

    // first bit is a fixed marker, then status bits 14..0 on falling edges
    always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            so_o <= `SWC_SO_MARKER;
        end else if (bit_cnt < `SWC_FRAME_BITS) begin
            so_o <= status_i[4'(`SWC_FRAME_LAST - bit_cnt)];
        end else begin
            so_o <= 1'b0;
        end
    end

endmodule

// ==== design/swc_top.sv ====
`timescale 1ns/100ps
`include "swc_map.svh"

module swc_top #(
    parameter int N_CH           = `SWC_CHANNELS,
    parameter int WAKE_W         = 23,
    parameter int STBY_WAKE_CYC  = int'(`SWC_STBY_WAKE_MS * `SWC_SYS_CLK_HZ / `SWC_MS_PER_S),
    parameter int RST_WAKE_CYC   = int'(`SWC_RST_WAKE_US * `SWC_SYS_CLK_HZ / `SWC_US_PER_S)
) (
    input  wire logic            sys_clk_i,           // system clock 25 MHz
    input  wire logic            reset_n_i,           // power-on / external reset
    input  wire logic            spi_sclk_i,          // serial clock
    input  wire logic            spi_cs_n_i,          // chip select, low active
    input  wire logic            spi_si_i,            // serial data in
    output logic                 spi_so_o,            // serial data out
    output logic                 spi_so_oe_o,         // serial out enable
    input  wire logic            direct_input_pin_a_i, // direct input a
    input  wire logic            direct_input_pin_b_i, // direct input b
    input  wire logic            direct_input_pin_c_i, // direct input c
    input  wire logic            direct_input_pin_d_i, // direct input d
    input  wire logic [N_CH-1:0] clamp_active_i,      // stage clamping flags
    output logic [N_CH-1:0]      channel_on_o,        // stage gate drive
    output logic [N_CH-1:0]      stage_clear_o,       // stage held in Clear
    output logic                 standby_o,           // all channels Clear
    output logic                 wake_busy_o,         // standby wake running
    output logic                 low_power_o,         // minimum current state
    output logic                 ready_o              // reset wake finished
);
    localparam int SYNC_W = 3 + `SWC_PINS + N_CH;
    // chip select idles high; a low reset value would fake a select edge after reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(1);

    // ---------------- reset release ----------------
    // reset asserts at once but leaves in step with the clock
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ---------------- serial link domain ----------------
    // the link keeps its own clock; only toggles and the held word come across
    swc_pkg::swc_frame_t  link_frame;
    swc_pkg::swc_status_t status;
    logic                 link_frame_tog;
    logic                 link_extra_tog;

    swc_spi_link u_link (
        .rst_n_i     (rst_n),
        .spi_sclk_i  (spi_sclk_i),
        .spi_cs_n_i  (spi_cs_n_i),
        .spi_si_i    (spi_si_i),
        .status_i    (status),
        .frame_o     (link_frame),
        .frame_tog_o (link_frame_tog),
        .extra_tog_o (link_extra_tog),
        .so_o        (spi_so_o)
    );

    // ---------------- synchronisers ----------------
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;

    assign sync_in = {clamp_active_i,
                      direct_input_pin_d_i, direct_input_pin_c_i,
                      direct_input_pin_b_i, direct_input_pin_a_i,
                      link_extra_tog, link_frame_tog, spi_cs_n_i};

    // levels here are slow against the clock, so a plain double flop per bit will do
    genvar gs;
    generate
        for (gs = 0; gs < SYNC_W; gs++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sync_a[gs] <= SYNC_IDLE[gs];
                    sync_b[gs] <= SYNC_IDLE[gs];
                end else begin
                    sync_a[gs] <= sync_in[gs];
                    sync_b[gs] <= sync_a[gs];
                end
            end
        end
    endgenerate

    logic                 cs_n_s;
    logic                 frame_tog_s;
    logic                 extra_tog_s;
    logic [3:0]           pins_s;
    logic [N_CH-1:0]      clamp_s;

    assign cs_n_s      = sync_b[0];
    assign frame_tog_s = sync_b[1];
    assign extra_tog_s = sync_b[2];
    assign pins_s      = sync_b[6:3];
    assign clamp_s     = sync_b[SYNC_W-1:7];

    // ---------------- frame tracking ----------------
    logic                cs_n_d;
    logic                frame_tog_d;
    logic                extra_tog_d;
    logic                frame_pend;
    logic                frame_bad;
    swc_pkg::swc_frame_t frame_hold;
    logic                cs_rise;
    logic                cs_fall;
    logic                cs_edge;
    logic                frame_new;
    logic                extra_new;
    logic                apply;

    assign cs_rise   = cs_n_s && !cs_n_d;
    assign cs_fall   = !cs_n_s && cs_n_d;
    assign cs_edge   = cs_rise || cs_fall;
    // toggles need no answer back, so the link side never waits on this clock
    assign frame_new = frame_tog_s != frame_tog_d;
    assign extra_new = extra_tog_s != extra_tog_d;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_d      <= 1'b1;
            frame_tog_d <= 1'b0;
            extra_tog_d <= 1'b0;
        end else begin
            cs_n_d      <= cs_n_s;
            frame_tog_d <= frame_tog_s;
            extra_tog_d <= extra_tog_s;
        end
    end

    // word is stable in the link register long before its toggle arrives here
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_hold <= '0;
        end else if (frame_new) begin
            frame_hold <= link_frame;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_pend <= 1'b0;
        end else if (frame_new) begin
            frame_pend <= 1'b1;
        end else if (cs_edge) begin
            frame_pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            frame_bad <= 1'b0;
        end else if (extra_new) begin
            frame_bad <= 1'b1;
        end else if (cs_edge) begin
            frame_bad <= 1'b0;
        end
    end

    // only a full, exact-length frame closed by chip select is acted on
    assign apply = cs_rise && frame_pend && !frame_bad && ready_o;

    // ---------------- reset wake ----------------
    // frames closing before ready are dropped; the host has to sit out the wake time
    logic [WAKE_W-1:0] rst_wake_cnt;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rst_wake_cnt <= '0;
            ready_o      <= 1'b0;
        end else if (!ready_o) begin
            if (rst_wake_cnt == WAKE_W'(RST_WAKE_CYC - 1)) begin
                ready_o <= 1'b1;
            end
            rst_wake_cnt <= rst_wake_cnt + WAKE_W'(1);
        end
    end

    // ---------------- channel mode and pin select ----------------
    // every two-bit code is a legal mode, so the decode needs no default
    function automatic swc_pkg::swc_mode_t mode_of(input logic [1:0] code);
        unique case (code)
            `SWC_MODE_OFF:   mode_of = swc_pkg::SWC_OFF;
            `SWC_MODE_ON:    mode_of = swc_pkg::SWC_ON;
            `SWC_MODE_CLEAR: mode_of = swc_pkg::SWC_CLEAR;
            `SWC_MODE_INPUT: mode_of = swc_pkg::SWC_INPUT;
        endcase
    endfunction

    // an open pin reads low through its pull-down, so its stages stay off
    function automatic logic pin_of(input logic [1:0] sel, input logic [3:0] pins);
        pin_of = pins[sel];
    endfunction

    swc_pkg::swc_mode_t ch_mode [N_CH];
    logic [1:0]         pin_sel [N_CH];
    logic [N_CH-1:0]    is_clear;
    logic [N_CH-1:0]    want_on;
    logic [N_CH-1:0]    next_on;
    logic               all_clear;
    logic               hold_off;

    // standby and its wake time veto every stage at once
    assign hold_off = wake_busy_o || standby_o;

    genvar gc;
    generate
        for (gc = 0; gc < N_CH; gc++) begin : g_ch
            logic hit;
            logic wr_mode;
            logic wr_sel;

            assign hit     = frame_hold.broadcast || frame_hold.channel == 3'(gc);
            assign wr_mode = apply && hit && frame_hold.op == `SWC_OP_MODE;
            assign wr_sel  = apply && hit && frame_hold.op == `SWC_OP_PINSEL;

            // reset leaves every channel in OFF
            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    ch_mode[gc] <= swc_pkg::SWC_OFF;
                end else if (wr_mode) begin
                    ch_mode[gc] <= mode_of(frame_hold.value);
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pin_sel[gc] <= `SWC_PINSEL_RESET;
                end else if (wr_sel) begin
                    pin_sel[gc] <= frame_hold.value;
                end
            end

            assign is_clear[gc] = ch_mode[gc] == swc_pkg::SWC_CLEAR;

            always_comb begin
                unique case (ch_mode[gc])
                    swc_pkg::SWC_ON:    want_on[gc] = 1'b1;
                    swc_pkg::SWC_INPUT: want_on[gc] = pin_of(pin_sel[gc], pins_s);
                    swc_pkg::SWC_OFF:   want_on[gc] = 1'b0;
                    swc_pkg::SWC_CLEAR: want_on[gc] = 1'b0;
                endcase
            end

            // a clamping stage stays off until the clamp has ended
            assign next_on[gc] = want_on[gc] && !clamp_s[gc] && !hold_off;
        end
    endgenerate

    assign all_clear = &is_clear;

    // ---------------- standby and its wake-up ----------------
    logic [WAKE_W-1:0] stby_wake_cnt;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_o <= 1'b0;
        end else begin
            standby_o <= all_clear;
        end
    end

    // wake starts on the cycle standby is left and runs a fixed count
    // the device holds ON back during the wake time instead of trusting the host
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stby_wake_cnt <= '0;
            wake_busy_o   <= 1'b0;
        end else if (all_clear) begin
            stby_wake_cnt <= '0;
            wake_busy_o   <= 1'b0;
        end else if (standby_o) begin
            stby_wake_cnt <= WAKE_W'(STBY_WAKE_CYC - 1);
            wake_busy_o   <= 1'b1;
        end else if (stby_wake_cnt != '0) begin
            stby_wake_cnt <= stby_wake_cnt - WAKE_W'(1);
        end else begin
            wake_busy_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            low_power_o <= 1'b1;
        end else begin
            low_power_o <= all_clear;
        end
    end

    // ---------------- output stages ----------------
    // gate and Clear flag come from one mode, so a stage in Clear is never driven on
    genvar go;
    generate
        for (go = 0; go < N_CH; go++) begin : g_out
            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    channel_on_o[go] <= 1'b0;
                end else begin
                    channel_on_o[go] <= next_on[go];
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    stage_clear_o[go] <= 1'b1;
                end else begin
                    stage_clear_o[go] <= is_clear[go];
                end
            end
        end
    endgenerate

    // ---------------- serial output and status ----------------
    // status only changes while chip select is high, so the link reads it steady
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else if (cs_n_s) begin
            status.marker    <= `SWC_SO_MARKER;
            status.standby   <= standby_o;
            status.wake_busy <= wake_busy_o;
            status.ready     <= ready_o;
            status.zero      <= 4'h0;
            status.clamp     <= clamp_s;
        end
    end

    // enable follows select low after the sync delay but drops one clock after select rises; no drive at all under reset
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            spi_so_oe_o <= 1'b0;
        end else begin
            spi_so_oe_o <= !cs_n_s && !spi_cs_n_i;
        end
    end

endmodule

// ==== verification/swc_top_sva.sv ====
`timescale 1ns/100ps

module swc_top_sva #(
    parameter int N_CH          = 8,
    parameter int STBY_WAKE_CYC = 20,
    parameter int RST_WAKE_CYC  = 10
) (
    input wire logic            sys_clk_i,      // system clock
    input wire logic            reset_n_i,      // reset, low active
    input wire logic            spi_cs_n_i,     // chip select
    input wire logic            spi_so_oe_o,    // serial out enable
    input wire logic [N_CH-1:0] clamp_active_i, // clamp flags
    input wire logic [N_CH-1:0] channel_on_o,   // gate drive
    input wire logic [N_CH-1:0] stage_clear_o,  // stage in Clear
    input wire logic            standby_o,      // standby
    input wire logic            wake_busy_o,    // wake running
    input wire logic            low_power_o,    // low current
    input wire logic            ready_o         // reset wake done
);
    logic [N_CH-1:0] cl1;
    logic [N_CH-1:0] cl2;
    logic [N_CH-1:0] cl3;
    logic [N_CH-1:0] steady;
    logic [31:0]     wcnt;
    logic [31:0]     rcnt;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // clamp must be seen for several cycles, the pins pass a 2-flop synchroniser
    assign steady = clamp_active_i & cl1 & cl2 & cl3;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cl1 <= '0;
            cl2 <= '0;
            cl3 <= '0;
        end else begin
            cl1 <= clamp_active_i;
            cl2 <= cl1;
            cl3 <= cl2;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wcnt <= 32'h0;
            rcnt <= 32'h0;
        end else begin
            wcnt <= wake_busy_o ? wcnt + 32'h1 : 32'h0;
            rcnt <= ready_o ? rcnt : rcnt + 32'h1;
        end
    end

    a_release_clear: assert property ($rose(reset_n_i) |-> stage_clear_o == '1 && low_power_o)
        else $error("stages not in Clear at reset release");
    a_leave_off: assert property ($rose(reset_n_i) |-> (channel_on_o == '0) [*8])
        else $error("channel on right after reset");
    a_clear_lifts: assert property ($rose(reset_n_i) |-> ##[2:8] stage_clear_o == '0)
        else $error("modes not OFF after reset");
    a_so_float: assert property (spi_cs_n_i |-> ##1 !spi_so_oe_o)
        else $error("serial out driven with chip select high");
    a_standby_all: assert property (standby_o |-> stage_clear_o == '1)
        else $error("standby without all channels Clear");
    a_standby_power: assert property (standby_o |-> low_power_o)
        else $error("standby without low power");
    a_on_clear_excl: assert property ((channel_on_o & stage_clear_o) == '0)
        else $error("channel on while in Clear");
    a_clamp_hold: assert property (((channel_on_o & ~$past(channel_on_o)) & steady) == '0)
        else $error("channel switched on during clamping");
    a_wake_block: assert property (wake_busy_o && $past(wake_busy_o) |-> (channel_on_o & ~$past(channel_on_o)) == '0)
        else $error("channel switched on during standby wake");
    a_wake_len: assert property ($fell(wake_busy_o) |-> wcnt == STBY_WAKE_CYC)
        else $error("standby wake length wrong");
    a_ready_time: assert property ($rose(ready_o) |-> rcnt >= RST_WAKE_CYC && rcnt <= RST_WAKE_CYC + 4)
        else $error("reset wake length wrong");

    c_standby: cover property ($rose(standby_o));
    c_wake: cover property ($rose(wake_busy_o));
    c_chan_on: cover property ($rose(channel_on_o[0]));
endmodule

// ==== verification/swc_host_model.sv ====
`timescale 1ns/100ps

module swc_host_model (
    output logic spi_sclk_o, // link clock, only inside frames
    output logic spi_cs_n_o, // chip select
    output logic spi_si_o,   // serial data
    input  wire logic spi_so_i    // resolved serial out line
);
    logic [16:0] rx;

    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_si_o   = 1'b0;
        rx         = 17'h00000;
    end

    // a 17th bit makes the frame invalid on purpose
    task automatic send(input logic [16:0] w, input logic extra);
        int n;
        n = extra ? 17 : 16;
        spi_cs_n_o = 1'b0;
        // select settles and the output driver turns on before the first edge
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            spi_si_o = w[i];
            #24;
            spi_sclk_o = 1'b1;
            rx = {rx[15:0], spi_so_i};
            #24;
            spi_sclk_o = 1'b0;
        end
        #30;
        spi_cs_n_o = 1'b1;
        // released data line falls to its pull-down level
        spi_si_o = 1'b0;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
    typedef struct packed {
        logic [15:0] w;
        logic [7:0]  on;
        logic [7:0]  clr;
        logic        sb;
    } swc_row_t;

    logic       sys_clk;
    logic       reset_n;
    logic [3:0] pins;
    logic [7:0] clamp;
    wire        sclk, cs_n, si, so, so_oe, stby, wake, lowp, rdy;
    wire  [7:0] ch_on, st_clr;
    int         n_fail;
    int         tests_run;
    swc_row_t   rows [6];

    swc_top #(.STBY_WAKE_CYC(20), .RST_WAKE_CYC(10)) u_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_oe), .direct_input_pin_a_i(pins[0]),
        .direct_input_pin_b_i(pins[1]), .direct_input_pin_c_i(pins[2]), .direct_input_pin_d_i(pins[3]),
        .clamp_active_i(clamp), .channel_on_o(ch_on), .stage_clear_o(st_clr), .standby_o(stby),
        .wake_busy_o(wake), .low_power_o(lowp), .ready_o(rdy));

    swc_host_model u_host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_si_o(si), .spi_so_i(so_oe ? so : ~so));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d failures=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // bounded wait while a level holds, then a margin for the output flops
    task automatic hold_while(input logic lvl, input int tail);
        int k;
        k = 0;
        while ((lvl ? wake : !rdy) === 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
        if (k >= 200) begin
            n_fail++;
            close_out();
        end
        cyc(tail);
    endtask

    task automatic frame(input logic [15:0] w, input logic extra);
        u_host.send({1'b0, w}, extra);
        cyc(12);
        hold_while(1'b1, 6);
    endtask

    function automatic logic [15:0] mk(input logic op, input logic [2:0] ch, input logic [1:0] v, input logic bc);
        swc_pkg::swc_frame_t f;
        f = '{op, ch, v, bc, 9'h000};
        return f;
    endfunction

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        n_fail    = 0;
        tests_run = 0;
        reset_n   = 1'b0;
        pins      = 4'h0;
        clamp     = 8'h00;
        cyc(5);
        reset_n = 1'b1;
        hold_while(1'b0, 2);
        chk(16'({ch_on, st_clr}), 16'h0000);
        rows[0] = '{mk(1'b0, 3'h0, swc_pkg::SWC_CLEAR, 1'b1), 8'h00, 8'hFF, 1'b1};
        rows[1] = '{mk(1'b0, 3'h0, swc_pkg::SWC_OFF, 1'b1), 8'h00, 8'h00, 1'b0};
        rows[2] = '{mk(1'b0, 3'h0, swc_pkg::SWC_ON, 1'b0), 8'h01, 8'h00, 1'b0};
        rows[3] = '{mk(1'b0, 3'h7, swc_pkg::SWC_ON, 1'b0), 8'h81, 8'h00, 1'b0};
        rows[4] = '{mk(1'b0, 3'h3, swc_pkg::SWC_INPUT, 1'b0), 8'h81, 8'h00, 1'b0};
        rows[5] = '{mk(1'b0, 3'h7, swc_pkg::SWC_OFF, 1'b0), 8'h01, 8'h00, 1'b0};
        foreach (rows[i]) begin
            frame(rows[i].w, 1'b0);
            chk(16'(ch_on), 16'(rows[i].on));
            chk(16'(st_clr), 16'(rows[i].clr));
            chk(16'(stby), 16'(rows[i].sb));
        end
        frame(mk(1'b0, 3'h1, swc_pkg::SWC_INPUT, 1'b0), 1'b0);
        for (int p = 0; p < 4; p++) begin
            frame(mk(1'b1, 3'h1, 2'(p), 1'b0), 1'b0);
            pins = 4'h1 << p;
            cyc(6);
            chk(16'(ch_on[1]), 16'h0001);
            pins = ~(4'h1 << p);
            cyc(6);
            chk(16'(ch_on[1]), 16'h0000);
        end
        pins = 4'h0;
        cyc(6);
        chk(16'(ch_on), 16'h0001);
        chk(16'({u_host.rx[15], u_host.rx[12]}), 16'h0003);
        frame(mk(1'b0, 3'h0, swc_pkg::SWC_OFF, 1'b0), 1'b1);
        chk(16'(ch_on[0]), 16'h0001);
        clamp = 8'h01;
        cyc(4);
        frame(mk(1'b0, 3'h0, swc_pkg::SWC_OFF, 1'b0), 1'b0);
        frame(mk(1'b0, 3'h0, swc_pkg::SWC_ON, 1'b0), 1'b0);
        chk(16'(ch_on[0]), 16'h0000);
        clamp = 8'h00;
        cyc(8);
        chk(16'(ch_on[0]), 16'h0001);
        frame(mk(1'b0, 3'h0, swc_pkg::SWC_CLEAR, 1'b1), 1'b0);
        chk(16'({stby, lowp, st_clr}), 16'h03FF);
        u_host.send({1'b0, mk(1'b0, 3'h0, swc_pkg::SWC_OFF, 1'b1)}, 1'b0);
        cyc(12);
        chk(16'({wake, stby}), 16'h0002);
        hold_while(1'b1, 6);
        frame(mk(1'b0, 3'h0, swc_pkg::SWC_ON, 1'b0), 1'b0);
        chk(16'(ch_on), 16'h0001);
        reset_n = 1'b0;
        cyc(3);
        chk(16'(st_clr), 16'h00FF);
        chk(16'({ch_on, lowp, so_oe, rdy}), 16'h0004);
        reset_n = 1'b1;
        hold_while(1'b0, 4);
        chk(16'({ch_on, st_clr}), 16'h0000);
        close_out();
    end
endmodule

bind swc_top swc_top_sva #(
    .N_CH(N_CH),
    .STBY_WAKE_CYC(STBY_WAKE_CYC),
    .RST_WAKE_CYC(RST_WAKE_CYC)
) u_sva (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(spi_cs_n_i), .spi_so_oe_o(spi_so_oe_o),
    .clamp_active_i(clamp_active_i), .channel_on_o(channel_on_o), .stage_clear_o(stage_clear_o),
    .standby_o(standby_o), .wake_busy_o(wake_busy_o), .low_power_o(low_power_o), .ready_o(ready_o));
